// ===== cmpc_top.sv
// Overview of operation
// (R1) The low and high compare bytes form one 16-bit compare value.
// (R2) Software reaches the 16-bit value through two byte-wide accesses.
// (R3) Software writes the high byte first and the low byte second.
// (R4) Software reads the low byte first and the high byte second.
// (R5) The active compare value is compared against the counter on every counting step.
// (R6) A match raises the interrupt flag and drives the waveform output pin.
// (R7) In PWM modes software writes land in a buffer, not the active value.
// (R8) In normal and clear-on-match modes writes reach the active value immediately.
// (R9) The buffer loads the active value only at counter top or bottom.
// (R10) With buffering on, byte accesses target the buffer.
// (R11) With buffering off, byte accesses target the active value.
// (R12) A high write waits in a temp latch until the low write; a low read loads the latch.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module cmpc_top (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        CE,
    // Timer side
    input  wire logic [15:0] COUNT,
    input  wire logic        COUNT_STEP,
    input  wire logic        COUNT_AT_TOP,
    input  wire logic        COUNT_AT_BOTTOM,
    output logic             MATCH,
    output logic             COMPARE_C_OUTPUT_PIN,
    output logic             IRQ,
    // AXI4-Lite slave
    input  wire logic [11:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [11:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [11:0] awaddr_ff;
    logic        aw_got_ff;
    logic [7:0]  wbyte_ff;
    logic        wlane_ff;
    logic        w_got_ff;
    logic [3:0]  ctrl_ff;
    logic [1:0]  status_ff;
    logic [1:0]  mask_ff;
    logic [7:0]  temp_ff;
    logic [15:0] active_ff;
    logic [15:0] buffer_ff;
    logic        pin_ff;
    logic        wr_fire;
    logic        wr_lane_ok;
    logic        rd_fire;
    logic        buffered;
    logic        wr_low;
    logic        wr_high;
    logic        rd_low;
    logic        rd_status;
    logic        hit;
    logic        load_evt;
    logic [15:0] cpu_view;
    logic [15:0] nxt_cmp;
    logic        cmp_load;
    logic [7:0]  nxt_temp;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;
    logic [1:0]  nxt_status;

    assign buffered = (ctrl_ff[cmpc_pkg::CTRL_MODE_MSB:cmpc_pkg::CTRL_MODE_LSB]
                       == cmpc_pkg::MODE_PWM_FAST)
                   || (ctrl_ff[cmpc_pkg::CTRL_MODE_MSB:cmpc_pkg::CTRL_MODE_LSB]
                       == cmpc_pkg::MODE_PWM_PC); // R7 R8

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    assign wr_fire    = aw_got_ff && w_got_ff && !BVALID;
    assign wr_lane_ok = wlane_ff;
    assign wr_low     = CE && wr_fire && wr_lane_ok && (awaddr_ff == cmpc_pkg::ADDR_CMP_LOW);
    assign wr_high    = CE && wr_fire && wr_lane_ok && (awaddr_ff == cmpc_pkg::ADDR_CMP_HIGH);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AWREADY   <= 1'b0;
            aw_got_ff <= 1'b0;
            awaddr_ff <= 12'h000;
        end else if (CE) begin
            AWREADY <= !aw_got_ff && AWVALID && !AWREADY;
            if (AWVALID && AWREADY) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= {AWADDR[11:2], 2'h0};
            end else if (wr_fire) begin
                aw_got_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WREADY   <= 1'b0;
            w_got_ff <= 1'b0;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
        end else if (CE) begin
            WREADY <= !w_got_ff && WVALID && !WREADY;
            if (WVALID && WREADY) begin
                w_got_ff <= 1'b1;
                wbyte_ff <= WDATA[7:0];
                wlane_ff <= WSTRB[0];
            end else if (wr_fire) begin
                w_got_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BVALID <= 1'b0;
            BRESP  <= cmpc_pkg::RESP_OKAY;
        end else if (CE) begin
            if (wr_fire) begin
                BVALID <= 1'b1;
                case (awaddr_ff)
                    cmpc_pkg::ADDR_CMP_LOW,
                    cmpc_pkg::ADDR_CMP_HIGH,
                    cmpc_pkg::ADDR_CTRL,
                    cmpc_pkg::ADDR_STATUS,
                    cmpc_pkg::ADDR_MASK,
                    cmpc_pkg::ADDR_ACTIVE: BRESP <= cmpc_pkg::RESP_OKAY;
                    default:               BRESP <= cmpc_pkg::RESP_SLVERR;
                endcase
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_ff <= cmpc_pkg::CTRL_RESET;
            mask_ff <= cmpc_pkg::IRQ_RESET;
        end else if (CE && wr_fire && wr_lane_ok) begin
            if (awaddr_ff == cmpc_pkg::ADDR_CTRL) begin
                ctrl_ff <= wbyte_ff[3:0];
            end
            if (awaddr_ff == cmpc_pkg::ADDR_MASK) begin
                mask_ff <= wbyte_ff[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare value, temp latch and double buffer

    assign cpu_view = buffered ? buffer_ff : active_ff; // R10 R11
    assign nxt_cmp  = {temp_ff, wbyte_ff}; // R1

    always_comb begin
        nxt_temp = temp_ff;
        if (wr_high) begin
            nxt_temp = wbyte_ff; // R12 R3
        end else if (rd_low) begin
            nxt_temp = cpu_view[15:8]; // R12 R4
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            temp_ff <= cmpc_pkg::CMP_BYTE_RESET;
        end else if (CE) begin
            temp_ff <= nxt_temp;
        end
    end

    assign load_evt = buffered && COUNT_STEP && (COUNT_AT_TOP || COUNT_AT_BOTTOM); // R9
    assign cmp_load = (wr_low && !buffered) || load_evt; // R8 R9

    cmpc_byte_reg u_active_lo (
        .clk    (CLK),
        .arst_n (ARST_N),
        .en     (CE),
        .load   (cmp_load),
        .d      (load_evt ? buffer_ff[7:0] : nxt_cmp[7:0]),
        .q      (active_ff[7:0])
    );

    cmpc_byte_reg u_active_hi (
        .clk    (CLK),
        .arst_n (ARST_N),
        .en     (CE),
        .load   (cmp_load),
        .d      (load_evt ? buffer_ff[15:8] : nxt_cmp[15:8]),
        .q      (active_ff[15:8])
    );

    // Buffer takes every low-byte write; only visible to the compare in PWM modes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            buffer_ff <= cmpc_pkg::CMP_RESET;
        end else if (CE && wr_low) begin
            buffer_ff <= nxt_cmp; // R7 R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, output pin and interrupt

    assign hit = COUNT_STEP && (COUNT == active_ff); // R5

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            MATCH  <= 1'b0;
            pin_ff <= 1'b0;
        end else if (CE) begin
            MATCH <= hit; // R6
            if (hit) begin
                case (ctrl_ff[cmpc_pkg::CTRL_COM_MSB:cmpc_pkg::CTRL_COM_LSB])
                    cmpc_pkg::COM_TOGGLE: pin_ff <= !pin_ff; // R6
                    cmpc_pkg::COM_CLEAR:  pin_ff <= 1'b0;
                    cmpc_pkg::COM_SET:    pin_ff <= 1'b1;
                    default:              pin_ff <= pin_ff;
                endcase
            end
        end
    end

    assign COMPARE_C_OUTPUT_PIN = pin_ff;

    assign rd_status = CE && rd_fire && (ARADDR[11:2] == cmpc_pkg::ADDR_STATUS[11:2]);

    always_comb begin
        nxt_status = status_ff;
        if (rd_status) begin
            nxt_status = 2'h0;
        end
        if (hit) begin
            nxt_status[cmpc_pkg::STAT_MATCH_BIT] = 1'b1; // R6
        end
        if (load_evt) begin
            nxt_status[cmpc_pkg::STAT_LOAD_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_ff <= cmpc_pkg::IRQ_RESET;
            IRQ       <= 1'b0;
        end else if (CE) begin
            status_ff <= nxt_status;
            IRQ       <= |(nxt_status & mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign rd_fire = ARVALID && ARREADY;
    assign rd_low  = CE && rd_fire && (ARADDR[11:2] == cmpc_pkg::ADDR_CMP_LOW[11:2]);

    always_comb begin
        nxt_rresp = cmpc_pkg::RESP_OKAY;
        nxt_rdata = 32'h0000_0000;
        case ({ARADDR[11:2], 2'h0})
            cmpc_pkg::ADDR_CMP_LOW:  nxt_rdata[7:0]  = cpu_view[7:0]; // R2 R10 R11
            cmpc_pkg::ADDR_CMP_HIGH: nxt_rdata[7:0]  = temp_ff; // R12 R4
            cmpc_pkg::ADDR_CTRL:     nxt_rdata[3:0]  = ctrl_ff;
            cmpc_pkg::ADDR_STATUS:   nxt_rdata[1:0]  = status_ff;
            cmpc_pkg::ADDR_MASK:     nxt_rdata[1:0]  = mask_ff;
            cmpc_pkg::ADDR_ACTIVE:   nxt_rdata[15:0] = active_ff;
            default:                 nxt_rresp       = cmpc_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= cmpc_pkg::RESP_OKAY;
        end else if (CE) begin
            ARREADY <= ARVALID && !ARREADY && !RVALID;
            if (rd_fire) begin
                RVALID <= 1'b1;
                RDATA  <= nxt_rdata;
                RRESP  <= nxt_rresp;
            end else if (RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_MATCH_FOLLOWS_HIT: assert property (@(posedge CLK) disable iff (!ARST_N) // R5
        CE && COUNT_STEP && COUNT == active_ff |=> MATCH)
        else $error("Match pulse missing after counter equals compare");

    AST_NO_MATCH_WITHOUT_STEP: assert property (@(posedge CLK) disable iff (!ARST_N) // R5
        CE && !COUNT_STEP |=> !MATCH)
        else $error("Match without a counting step");

    AST_MATCH_SETS_FLAG: assert property (@(posedge CLK) disable iff (!ARST_N) // R6
        CE && hit |=> status_ff[cmpc_pkg::STAT_MATCH_BIT])
        else $error("Match flag not set");

    AST_TOGGLE_PIN: assert property (@(posedge CLK) disable iff (!ARST_N) // R6
        CE && hit && ctrl_ff[3:2] == cmpc_pkg::COM_TOGGLE |=> pin_ff != $past(pin_ff))
        else $error("Pin did not toggle on match");

    AST_PWM_WRITE_HELD: assert property (@(posedge CLK) disable iff (!ARST_N) // R7
        buffered && !load_evt |=> active_ff == $past(active_ff))
        else $error("Active value changed outside load point in PWM");

    AST_DIRECT_WRITE: assert property (@(posedge CLK) disable iff (!ARST_N) // R8
        wr_low && !buffered |=> active_ff == $past(nxt_cmp))
        else $error("Direct write did not reach active value");

    AST_LOAD_AT_EDGE: assert property (@(posedge CLK) disable iff (!ARST_N) // R9
        CE && load_evt |=> active_ff == $past(buffer_ff))
        else $error("Buffer not transferred at top or bottom");

    AST_HIGH_HELD_IN_TEMP: assert property (@(posedge CLK) disable iff (!ARST_N) // R12
        wr_high && !load_evt |=> temp_ff == $past(wbyte_ff) ##0 active_ff == $past(active_ff))
        else $error("High byte write not held in temp");

    AST_LOW_READ_CAPTURES: assert property (@(posedge CLK) disable iff (!ARST_N) // R12
        rd_low && !wr_high |=> temp_ff == $past(cpu_view[15:8]))
        else $error("Low read did not capture high byte");

    AST_READ_ANSWER: assert property (@(posedge CLK) disable iff (!ARST_N) // R2
        CE && rd_fire |=> RVALID)
        else $error("Read answer missing");

endmodule

`default_nettype wire

// ===== cmpc_pkg.sv
package cmpc_pkg;

    // Register byte addresses, each register one aligned 32-bit word.
    // Printed offsets 0x9E and 0x9F are not multiples of four, so they are indices.
    localparam logic [7:0]  IDX_CMP_LOW    = 8'h9E;
    localparam logic [7:0]  IDX_CMP_HIGH   = 8'h9F;
    localparam logic [11:0] ADDR_CMP_LOW   = {2'h0, IDX_CMP_LOW, 2'h0};
    localparam logic [11:0] ADDR_CMP_HIGH  = {2'h0, IDX_CMP_HIGH, 2'h0};
    localparam logic [11:0] ADDR_CTRL      = 12'h400;
    localparam logic [11:0] ADDR_STATUS    = 12'h404;
    localparam logic [11:0] ADDR_MASK      = 12'h408;
    localparam logic [11:0] ADDR_ACTIVE    = 12'h40C;

    // Field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_MODE_MSB  = 1;
    localparam int CTRL_COM_LSB   = 2;
    localparam int CTRL_COM_MSB   = 3;
    localparam int STAT_MATCH_BIT = 0;
    localparam int STAT_LOAD_BIT  = 1;

    // Reset values
    localparam logic [7:0]  CMP_BYTE_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET      = 16'h0000;
    localparam logic [3:0]  CTRL_RESET     = 4'h0;
    localparam logic [1:0]  IRQ_RESET      = 2'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Waveform mode select
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_CTC    = 2'b01,
        MODE_PWM_FAST = 2'b10,
        MODE_PWM_PC = 2'b11
    } wave_mode_e;

    // Output action on match
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

endpackage

// ===== cmpc_byte_reg.sv
`timescale 1ns/10ps
`default_nettype none

module cmpc_byte_reg (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       en,
    input  wire logic       load,
    input  wire logic [7:0] d,
    output var  logic [7:0] q
);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= cmpc_pkg::CMP_BYTE_RESET;
        end else if (en && load) begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// ===== cmpc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            mismatches++; \
            $display("wrong value %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module cmpc_top_tb;

    logic        clk, arst_n, ce, count_step, at_top, at_bot;
    logic [15:0] count;
    logic        match, pin, irq;
    logic [11:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          mismatches, check_count;

    cmpc_top i_dut (.CLK(clk), .ARST_N(arst_n), .CE(ce), .COUNT(count),
        .COUNT_STEP(count_step), .COUNT_AT_TOP(at_top), .COUNT_AT_BOTTOM(at_bot),
        .MATCH(match), .COMPARE_C_OUTPUT_PIN(pin), .IRQ(irq),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bus_fail();
        mismatches++;
        $display("wrong value bus wait expected answer seen timeout");
        conclude();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        while (!(bvalid && bready)) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (n > 50) bus_fail();
        end
        bready <= 1'b0;
        `CHK("write response", er, bresp)
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        n = 0;
        while (!(rvalid && rready)) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (n > 50) bus_fail();
        end
        rready <= 1'b0;
        `CHK("read response", er, rresp)
        `CHK("read data", ed, rdata)
    endtask

    task automatic wr16(input logic [15:0] v);
        wr(cmpc_pkg::ADDR_CMP_HIGH, {24'h0, v[15:8]}, 4'hF, cmpc_pkg::RESP_OKAY);
        wr(cmpc_pkg::ADDR_CMP_LOW, {24'h0, v[7:0]}, 4'hF, cmpc_pkg::RESP_OKAY);
    endtask

    task automatic rd16(input logic [15:0] v);
        rd(cmpc_pkg::ADDR_CMP_LOW, {24'h0, v[7:0]}, cmpc_pkg::RESP_OKAY);
        rd(cmpc_pkg::ADDR_CMP_HIGH, {24'h0, v[15:8]}, cmpc_pkg::RESP_OKAY);
    endtask

    task automatic ctrl(input logic [1:0] m, input logic [1:0] com);
        wr(cmpc_pkg::ADDR_CTRL, {28'h0, com, m}, 4'hF, cmpc_pkg::RESP_OKAY);
    endtask

    task automatic step(input logic [15:0] c, input logic top, input logic bot);
        @(posedge clk);
        count <= c; count_step <= 1'b1; at_top <= top; at_bot <= bot;
        @(posedge clk);
        count_step <= 1'b0; at_top <= 1'b0; at_bot <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(cmpc_pkg::ADDR_CMP_LOW, 32'h0, cmpc_pkg::RESP_OKAY);
        rd(cmpc_pkg::ADDR_CMP_HIGH, 32'h0, cmpc_pkg::RESP_OKAY);
        rd(cmpc_pkg::ADDR_CTRL, 32'h0, cmpc_pkg::RESP_OKAY);
        rd(cmpc_pkg::ADDR_STATUS, 32'h0, cmpc_pkg::RESP_OKAY);
        rd(cmpc_pkg::ADDR_MASK, 32'h0, cmpc_pkg::RESP_OKAY);
        rd(cmpc_pkg::ADDR_ACTIVE, 32'h0, cmpc_pkg::RESP_OKAY);
        rd(12'h010, 32'h0, cmpc_pkg::RESP_SLVERR);
        wr(12'h010, 32'h5A, 4'hF, cmpc_pkg::RESP_SLVERR);
    endtask

    task automatic t_direct();
        logic [15:0] v;
        for (int m = 0; m < 2; m++) begin
            v = 16'hA5C3 ^ 16'(m * 16'h1111);
            ctrl(2'(m), cmpc_pkg::COM_NONE);
            wr16(v);
            rd(cmpc_pkg::ADDR_ACTIVE, {16'h0, v}, cmpc_pkg::RESP_OKAY);
            rd16(v);
            wr(cmpc_pkg::ADDR_CMP_LOW, 32'h77, 4'hE, cmpc_pkg::RESP_OKAY);
            rd(cmpc_pkg::ADDR_ACTIVE, {16'h0, v}, cmpc_pkg::RESP_OKAY);
        end
    endtask

    task automatic t_match();
        ctrl(cmpc_pkg::MODE_NORMAL, cmpc_pkg::COM_TOGGLE);
        wr16(16'h1234);
        step(16'h1233, 1'b0, 1'b0);
        `CHK("match", 1'b0, match)
        step(16'h1234, 1'b0, 1'b0);
        `CHK("match", 1'b1, match)
        `CHK("pin", 1'b1, pin)
        `CHK("irq masked", 1'b0, irq)
        rd(cmpc_pkg::ADDR_STATUS, 32'h1, cmpc_pkg::RESP_OKAY);
        rd(cmpc_pkg::ADDR_STATUS, 32'h0, cmpc_pkg::RESP_OKAY);
        wr(cmpc_pkg::ADDR_MASK, 32'h1, 4'hF, cmpc_pkg::RESP_OKAY);
        ce <= 1'b0;
        step(16'h1234, 1'b0, 1'b0);
        `CHK("match frozen", 1'b0, match)
        @(posedge clk);
        ce <= 1'b1;
        step(16'h1234, 1'b0, 1'b0);
        `CHK("match", 1'b1, match)
        `CHK("pin", 1'b0, pin)
        `CHK("irq", 1'b1, irq)
        rd(cmpc_pkg::ADDR_STATUS, 32'h1, cmpc_pkg::RESP_OKAY);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        ctrl(cmpc_pkg::MODE_NORMAL, cmpc_pkg::COM_SET);
        step(16'h1234, 1'b0, 1'b0);
        `CHK("pin set", 1'b1, pin)
        ctrl(cmpc_pkg::MODE_NORMAL, cmpc_pkg::COM_CLEAR);
        step(16'h1234, 1'b0, 1'b0);
        `CHK("pin clear", 1'b0, pin)
        `CHK("irq", 1'b1, irq)
        rd(cmpc_pkg::ADDR_STATUS, 32'h1, cmpc_pkg::RESP_OKAY);
    endtask

    task automatic t_buffered();
        logic [15:0] v;
        for (int m = 2; m < 4; m++) begin
            v = 16'h2222 + 16'(m);
            ctrl(cmpc_pkg::MODE_NORMAL, cmpc_pkg::COM_NONE);
            wr16(16'h1111);
            ctrl(2'(m), cmpc_pkg::COM_NONE);
            wr16(v);
            rd(cmpc_pkg::ADDR_ACTIVE, 32'h1111, cmpc_pkg::RESP_OKAY);
            rd16(v);
            rd(cmpc_pkg::ADDR_STATUS, 32'h0, cmpc_pkg::RESP_OKAY);
            step(16'h0500, 1'b0, 1'b0);
            rd(cmpc_pkg::ADDR_ACTIVE, 32'h1111, cmpc_pkg::RESP_OKAY);
            step((m == 2) ? 16'hFFFF : 16'h0000, m == 2, m == 3);
            rd(cmpc_pkg::ADDR_ACTIVE, {16'h0, v}, cmpc_pkg::RESP_OKAY);
            rd(cmpc_pkg::ADDR_STATUS, 32'h2, cmpc_pkg::RESP_OKAY);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0; ce = 1'b1; count = 16'h0; count_step = 1'b0;
        at_top = 1'b0; at_bot = 1'b0;
        awaddr = 12'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
        bready = 1'b0; araddr = 12'h0; arvalid = 1'b0; rready = 1'b0;
        mismatches = 0; check_count = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_direct();
        t_match();
        t_buffered();
        conclude();
    end

endmodule
`default_nettype wire
